// ==== inc/cfg_loader_defines.vh ====
`ifndef CFG_LOADER_DEFINES_VH
`define CFG_LOADER_DEFINES_VH
// Serial clock: half period in sys_clk cycles (oscillator default rate)
`define SCK_HALF_DEFAULT 8'h04
`define SCK_HALF_FAST 8'h01
// Commands
`define CMD_WAKE 8'hab
`define CMD_READ 8'h03
`define IMAGE_ADDR 24'h000000
// Gap after wake command: 10 us at 25 MHz, rounded up
`define GAP_NS 10000
`define CLK_NS 40
`define GAP_CYCLES ((`GAP_NS + `CLK_NS - 1) / `CLK_NS)
// Reset pulse: 200 ns at 25 MHz, rounded up
`define RST_NS 200
`define RST_CYCLES ((`RST_NS + `CLK_NS - 1) / `CLK_NS)
// Bits in read header: command plus address
`define READ_BITS 6'd32
`define WAKE_BITS 6'd8
`endif

// ==== design/spi_shifter.v ====
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"
module spi_shifter
(
    input wire sys_clk,
    input wire resetn,
    input wire start,
    input wire [31:0] word,
    input wire [5:0] nbits,
    input wire [7:0] half,
    input wire hold,
    output reg sck,
    output reg mosi,
    output reg done,
    output reg fall
)
;
    reg [31:0] shreg;
    reg [5:0] left;
    reg [7:0] div;
    reg busy;
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shreg <= 32'h00000000;
            left <= 6'h00;
            div <= 8'h00;
            busy <= 1'b0;
            sck <= 1'b0;
            mosi <= 1'b0;
            done <= 1'b0;
            fall <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            fall <= 1'b0;
            if (start && !busy)
            begin
                busy <= 1'b1;
                shreg <= word << 1;
                mosi <= word[31];
                left <= nbits;
                div <= 8'h00;
                sck <= 1'b0;
            end
            else if (busy)
            begin
                // Equal high and low phases from one divider
                // Compare is >= so a rate change mid-phase never waits for a wrap
                if (div >= half - 8'h01)
                begin
                    div <= 8'h00;
                    if (!sck)
                    begin
                        sck <= 1'b1;
                        if (left != 6'h00)
                            left <= left - 6'h01;
                    end
                    else if (left == 6'h00 && !hold)
                    begin
                        sck <= 1'b0;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                    else
                    begin
                        // Data moves on the falling edge
                        sck <= 1'b0;
                        fall <= 1'b1;
                        mosi <= shreg[31];
                        shreg <= shreg << 1;
                    end
                end
                else
                begin
                    div <= div + 8'h01;
                end
            end
        end
    end
endmodule

// ==== design/config_loader.v ====
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"
module config_loader
(
    input wire sys_clk,
    input wire resetn,
    input wire config_reset_n,
    input wire jtag_trst_n,
    input wire jtag_cfg_done,
    input wire spi_sel_in,
    input wire spi_si,
    input wire fast_osc_req,
    input wire image_end,
    output reg spi_sel_out,
    output reg spi_sel_oe,
    output reg spi_sck,
    output reg spi_so,
    output reg config_done,
    output reg slave_mode,
    output reg read_active,
    output reg [7:0] read_data,
    output reg read_valid
)
;
    localparam S_RESET = 3'd0;
    localparam S_MODE = 3'd1;
    localparam S_WAKE = 3'd2;
    localparam S_GAP = 3'd3;
    localparam S_READ = 3'd4;
    localparam S_DATA = 3'd5;
    localparam S_DONE = 3'd6;
    localparam S_SLAVE = 3'd7;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [4:0] sync1;
    reg [4:0] sync2;
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1 <= 5'h01;
            sync2 <= 5'h01;
        end
        else
        begin
            sync1 <= {image_end, jtag_cfg_done, jtag_trst_n, spi_sel_in, config_reset_n};
            sync2 <= sync1;
        end
    end
    wire crst_s = sync2[0];
    wire sel_s = sync2[1];
    wire trst_s = sync2[2];
    wire jdone_s = sync2[3];
    wire iend_s = sync2[4];

    // ------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------
    reg [7:0] low_cnt;
    reg cold;
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_cnt <= 8'h00;
            cold <= 1'b1;
        end
        else
        begin
            cold <= 1'b0;
            if (!crst_s)
            begin
                if (low_cnt != 8'hff)
                    low_cnt <= low_cnt + 8'h01;
            end
            else
            begin
                // Short glitches below the minimum pulse are ignored
                if (low_cnt >= (`RST_CYCLES))
                    cold <= 1'b1;
                low_cnt <= 8'h00;
            end
        end
    end
    // Held reset also covers a slow PROM kept waiting outside
    wire held = !crst_s && low_cnt >= (`RST_CYCLES);
    // Power-on (resetn), reset pin, and JTAG test reset all clear logic
    wire soft_rst = held || cold || trst_s;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    reg [2:0] state;
    reg [13:0] gap;
    reg start;
    reg [31:0] word;
    reg [5:0] nbits;
    reg hold;
    reg fast;
    reg [7:0] shin;
    reg [2:0] bitc;
    wire sck_w;
    wire mosi_w;
    wire sh_done;
    wire [7:0] half = fast ? `SCK_HALF_FAST : `SCK_HALF_DEFAULT;
    reg sck_d;

    spi_shifter u_shift
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(start),
        .word(word),
        .nbits(nbits),
        .half(half),
        .hold(hold),
        .sck(sck_w),
        .mosi(mosi_w),
        .done(sh_done),
        .fall()
    );

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= S_RESET;
            gap <= 14'h0000;
            start <= 1'b0;
            word <= 32'h00000000;
            nbits <= 6'h00;
            hold <= 1'b0;
            fast <= 1'b0;
            shin <= 8'h00;
            bitc <= 3'h0;
            sck_d <= 1'b0;
            spi_sel_out <= 1'b1;
            spi_sel_oe <= 1'b0;
            spi_sck <= 1'b0;
            spi_so <= 1'b0;
            config_done <= 1'b0;
            slave_mode <= 1'b0;
            read_active <= 1'b0;
            read_data <= 8'h00;
            read_valid <= 1'b0;
        end
        else if (soft_rst)
        begin
            state <= S_RESET;
            start <= 1'b0;
            hold <= 1'b0;
            fast <= 1'b0;
            spi_sel_out <= 1'b1;
            spi_sel_oe <= 1'b0;
            spi_sck <= 1'b0;
            spi_so <= 1'b0;
            config_done <= 1'b0;
            slave_mode <= 1'b0;
            read_active <= 1'b0;
            read_valid <= 1'b0;
        end
        else
        begin
            start <= 1'b0;
            read_valid <= 1'b0;
            sck_d <= sck_w;
            spi_sck <= sck_w;
            spi_so <= mosi_w;
            case (state)
                S_RESET:
                    state <= S_MODE;
                S_MODE:
                begin
                    if (sel_s)
                    begin
                        spi_sel_oe <= 1'b1;
                        spi_sel_out <= 1'b0;
                        word <= {`CMD_WAKE, 24'h000000};
                        nbits <= `WAKE_BITS;
                        hold <= 1'b0;
                        start <= 1'b1;
                        state <= S_WAKE;
                    end
                    else
                    begin
                        slave_mode <= 1'b1;
                        state <= S_SLAVE;
                    end
                end
                S_WAKE:
                begin
                    // Input ignored during the wake command
                    if (sh_done)
                    begin
                        spi_sel_out <= 1'b1;
                        gap <= 14'h0000;
                        state <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    if (gap >= (`GAP_CYCLES) - 1)
                    begin
                        spi_sel_out <= 1'b0;
                        gap <= 14'h0000;
                        word <= {`CMD_READ, `IMAGE_ADDR};
                        nbits <= `READ_BITS;
                        hold <= 1'b1;
                        start <= 1'b1;
                        state <= S_READ;
                    end
                    else
                        gap <= gap + 14'h0001;
                end
                S_READ:
                begin
                    // Gap counter reused to count header clocks
                    if (sck_w && !sck_d && !start)
                    begin
                        gap <= gap + 14'h0001;
                        if (gap == {8'h00, `READ_BITS} - 14'h0001)
                        begin
                            read_active <= 1'b1;
                            state <= S_DATA;
                        end
                    end
                    bitc <= 3'h0;
                end
                S_DATA:
                begin
                    // Sample on rising edge
                    if (sck_w && !sck_d)
                    begin
                        shin <= {shin[6:0], spi_si};
                        bitc <= bitc + 3'h1;
                        if (bitc == 3'h7)
                        begin
                            read_data <= {shin[6:0], spi_si};
                            read_valid <= 1'b1;
                        end
                    end
                    if (fast_osc_req)
                        fast <= 1'b1;
                    if (iend_s)
                        hold <= 1'b0;
                    // Let the shifter end its clock so no high phase is cut short
                    if (!hold && sh_done)
                    begin
                        spi_sel_out <= 1'b1;
                        read_active <= 1'b0;
                        config_done <= 1'b1;
                        state <= S_DONE;
                    end
                end
                S_DONE:
                    spi_sel_oe <= 1'b0;
                S_SLAVE:
                begin
                    // Alternate load through boundary scan
                    if (jdone_s)
                    begin
                        config_done <= 1'b1;
                        state <= S_DONE;
                    end
                end
                default:
                    state <= S_RESET;
            endcase
        end
    end
endmodule

// ==== bench/config_loader_assertions.sv ====
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"
module config_loader_assertions
(
    input wire sys_clk,
    input wire resetn,
    input wire fast_osc_req,
    input wire spi_sel_out,
    input wire spi_sel_oe,
    input wire spi_sck,
    input wire spi_so,
    input wire config_done,
    input wire slave_mode,
    input wire read_active,
    input wire read_valid
);
    // ----
    // Helper counts
    // ----
    reg [8:0] gap;
    reg [3:0] rises;
    reg [1:0] frames;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gap <= 9'h0;
            rises <= 4'h0;
            frames <= 2'h0;
        end
        else
        begin
            gap <= (spi_sel_out && spi_sel_oe) ? gap + {8'h0, gap != 9'h1ff} : 9'h0;
            rises <= spi_sel_out ? 4'h0 : rises + {3'h0, $rose(spi_sck) && rises != 4'hf};
            if ($fell(spi_sel_out) && frames != 2'h3)
                frames <= frames + 2'h1;
        end
    end
    sequence s_wake_end;
        $rose(spi_sel_out) && frames == 2'h1;
    endsequence
    sequence s_done;
        $rose(config_done);
    endsequence
    // ----
    // Checks
    // ----
    a_sck_duty: assert property ($rose(spi_sck) && !fast_osc_req |-> spi_sck[*4] ##1 !spi_sck)
        else $error("serial clock half period wrong");
    a_sck_idle: assert property (spi_sel_out |-> !spi_sck)
        else $error("serial clock high while deselected");
    a_so_on_fall: assert property (!spi_sel_out && $changed(spi_so) |-> !spi_sck)
        else $error("data changed while clock high");
    a_sel_driven: assert property (!spi_sel_out |-> spi_sel_oe)
        else $error("select low but not driven");
    a_slave_quiet: assert property (slave_mode |-> !spi_sel_oe && !spi_sck)
        else $error("slave mode drives the link");
    a_wake_bits: assert property (s_wake_end |-> rises == 4'h8)
        else $error("wake frame not eight bits");
    a_gap_min: assert property ($fell(spi_sel_out) && $past(spi_sel_oe) |-> gap >= `GAP_CYCLES)
        else $error("command gap too short");
    a_done_release: assert property (s_done |-> spi_sel_out ##1 !spi_sel_oe)
        else $error("select not released at done");
    a_byte_pulse: assert property (read_valid |-> (read_active && !spi_sel_out) ##1 !read_valid)
        else $error("byte strobe outside data phase");
endmodule
bind config_loader config_loader_assertions u_chk
(
    .sys_clk(sys_clk), .resetn(resetn), .fast_osc_req(fast_osc_req),
    .spi_sel_out(spi_sel_out), .spi_sel_oe(spi_sel_oe), .spi_sck(spi_sck),
    .spi_so(spi_so), .config_done(config_done), .slave_mode(slave_mode),
    .read_active(read_active), .read_valid(read_valid)
);

// ==== bench/spi_prom_model.sv ====
`timescale 1ns/1ps
module spi_prom_model
(
    input wire sel_n,
    input wire sck,
    input wire so,
    output reg si
);
    reg [31:0] sr = 32'h0;
    reg [31:0] hdr = 32'h0;
    reg [7:0] last_cmd = 8'h0;
    reg [7:0] img [0:3];
    reg deep = 1'b1;
    int nbit = 0;
    int nwake = 0;
    initial si = 1'b0;
    // Ready at once, so no power-up wait
    always @(posedge sck)
    begin
        if (!sel_n)
        begin
            sr = {sr[30:0], so};
            nbit++;
            if (nbit == 32)
                hdr = sr;
        end
    end
    // Junk outside the data phase so no stale level is trusted
    always @(negedge sck)
    begin
        if (!sel_n && nbit >= 32)
            si = img[(nbit - 32) / 8][7 - (nbit - 32) % 8];
        else
            si = ~si;
    end
    always @(posedge sel_n)
    begin
        if (nbit == 8)
            last_cmd = sr[7:0];
        if (nbit == 8 && sr[7:0] == 8'hab)
        begin
            deep = 1'b0;
            nwake++;
        end
        if (nbit == 8 && sr[7:0] == 8'hb9)
            deep = 1'b1;
        nbit = 0;
        si = ~si;
    end
endmodule

// ==== bench/config_loader_tb.sv ====
`timescale 1ns/1ps
module config_loader_tb;
    reg sys_clk = 1'b0;
    reg resetn = 1'b0;
    reg config_reset_n = 1'b1;
    reg jtag_trst_n = 1'b0;
    reg jtag_cfg_done = 1'b0;
    reg fast_osc_req = 1'b0;
    reg image_end = 1'b0;
    reg strap = 1'b1;
    wire spi_sel_out, spi_sel_oe, spi_sck, spi_so, spi_si;
    wire config_done, slave_mode, read_active, read_valid;
    wire [7:0] read_data;
    // Strap level (strap) on the select pin when nobody drives it
    wire sel_pin = spi_sel_oe ? spi_sel_out : strap;
    int err_total = 0;
    int checks_done = 0;
    logic [7:0] q[$];
    initial forever #20 sys_clk = ~sys_clk;
    config_loader DUT
    (
        .sys_clk(sys_clk), .resetn(resetn), .config_reset_n(config_reset_n),
        .jtag_trst_n(jtag_trst_n), .jtag_cfg_done(jtag_cfg_done), .spi_sel_in(sel_pin),
        .spi_si(spi_si), .fast_osc_req(fast_osc_req), .image_end(image_end),
        .spi_sel_out(spi_sel_out), .spi_sel_oe(spi_sel_oe), .spi_sck(spi_sck),
        .spi_so(spi_so), .config_done(config_done), .slave_mode(slave_mode),
        .read_active(read_active), .read_data(read_data), .read_valid(read_valid)
    );
    spi_prom_model prom (.sel_n(sel_pin), .sck(spi_sck), .so(spi_so), .si(spi_si));
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task fill;
        int i;
        image_end <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            prom.img[i] = $urandom;
            q.push_back(prom.img[i]);
        end
    endtask
    task wait_done;
        int i;
        for (i = 0; i < 3000 && config_done !== 1'b1; i++)
            @(posedge sys_clk);
        tick(2);
        chk("config_done", config_done, 1'b1);
        chk("spi_sel_oe", spi_sel_oe, 1'b0);
        chk("bytes left", q.size(), 0);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----
    // Result monitor
    // ----
    always @(posedge sys_clk)
    begin
        if (read_valid === 1'b1)
        begin
            if (q.size() == 0)
                chk("extra byte", 1, 0);
            else
                chk("read_data", read_data, q.pop_front());
            image_end <= (q.size() == 0);
        end
    end
    initial
    begin
        tick(20000);
        err_total++;
        wrap_up();
    end
    // ----
    // Tests
    // ----
    initial
    begin
        void'($urandom(91057));
        fill();
        tick(8);
        resetn <= 1'b1;
        wait_done();
        chk("wake cmd", prom.last_cmd, 8'hab);
        chk("header", prom.hdr, 32'h03000000);
        chk("prom awake", prom.deep, 1'b0);
        $display("end master boot");
        config_reset_n <= 1'b0;
        tick(3);
        config_reset_n <= 1'b1;
        tick(8);
        chk("short pulse", config_done, 1'b1);
        fill();
        fast_osc_req <= 1'b1;
        config_reset_n <= 1'b0;
        tick(10);
        chk("in reset", config_done, 1'b0);
        config_reset_n <= 1'b1;
        wait_done();
        chk("wake count", prom.nwake, 2);
        $display("end cold boot");
        jtag_trst_n <= 1'b1;
        tick(20);
        chk("jtag hold", config_done, 1'b0);
        strap <= 1'b0;
        jtag_trst_n <= 1'b0;
        tick(10);
        chk("slave_mode", slave_mode, 1'b1);
        jtag_cfg_done <= 1'b1;
        wait_done();
        $display("end slave and scan");
        wrap_up();
    end
endmodule
